// >>> prhb_map.svh
// Purpose: constants for the programmed I/O request header builder
// Assumes: one 64-bit header per request, credits numbered 0 to 15
// Notes:   field positions are inclusive bit indices of the header word; PRHB_IO_SEL_BIT indexes the physical address
`ifndef PRHB_MAP_SVH
`define PRHB_MAP_SVH

`define PRHB_RESV_HI      63
`define PRHB_RESV_LO      61
`define PRHB_RD_BIT       60
`define PRHB_CREDIT_HI    59
`define PRHB_CREDIT_LO    56
`define PRHB_SIZE_HI      55
`define PRHB_SIZE_LO      48
`define PRHB_TAG_HI       47
`define PRHB_TAG_LO       40
`define PRHB_ZERO_HI      39
`define PRHB_ZERO_LO      38
`define PRHB_CMD_HI       37
`define PRHB_CMD_LO       36
`define PRHB_ADDR_HI      35
`define PRHB_ADDR_LO      0
`define PRHB_IO_SEL_BIT   28

`define PRHB_CREDITS      16
`define PRHB_CMD_MEM64    2'h3
`define PRHB_CMD_MEM32    2'h2
`define PRHB_BUF_NORMAL   2'h0
`define PRHB_BUF_TEST     2'h1
`define PRHB_SIZE_16B     3'h4
`define PRHB_ADDR_RST     36'h0
`define PRHB_FREE_RST     16'hFFFF

`endif

// >>> prhb_pkg.sv
// Purpose: shared types for the programmed I/O request header builder
// Assumes: nothing beyond the constants header
// Notes:   only types live here
package prhb_pkg;

	typedef enum logic [1:0] {
		PRHB_SPACE_MEM64,
		PRHB_SPACE_MEM32,
		PRHB_SPACE_IO_CFG
	} prhb_space_t;

	typedef logic [3:0] prhb_credit_t;

endpackage

// >>> prhb_builder.sv
// Purpose: build request headers for the pci_io_unit, track credits, format read returns
// Assumes: all inputs come from logic on ref_clk; read data arrives with its credit tag
// Notes:   a read return also frees its credit; write credits come back on credit_ret
`timescale 1ns/10ps
`default_nettype none
`include "prhb_map.svh"

module prhb_builder (
	// clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      sys_rst,
	// request from processor_to_cache_crossbar
	input  wire logic                      req_valid,
	input  wire logic                      req_is_read,
	input  wire logic [7:0]                req_size,
	input  wire logic [5:0]                req_cpu_thread_id,
	input  wire logic                      req_from_test_port,
	input  wire logic [39:0]               req_physical_address,
	input  wire prhb_pkg::prhb_space_t     req_space,
	// configured address mask
	input  wire logic [35:0]               cfg_addr_mask,
	// header toward pci_io_unit
	output logic                           req_ready,
	output logic                           hdr_valid,
	output logic [63:0]                    hdr_data,
	// credit return for writes
	input  wire logic                      credit_ret_valid,
	input  wire prhb_pkg::prhb_credit_t    credit_ret_tag,
	// read return from pci_io_unit
	input  wire logic                      rd_ret_valid,
	input  wire prhb_pkg::prhb_credit_t    rd_ret_tag,
	input  wire logic [127:0]              rd_ret_data,
	// read return toward the crossbar
	output logic                           cpu_ret_valid,
	output logic [127:0]                   cpu_ret_data,
	output prhb_pkg::prhb_credit_t         cpu_ret_tag,
	// status
	output logic [4:0]                     outstanding
);

	logic                   req_ready_ff;
	logic                   hdr_valid_ff;
	logic [63:0]            hdr_data_ff;
	logic [15:0]            free_ff;
	logic [15:0]            nxt_free;
	logic [15:0]            full16_ff;
	logic                   cpu_ret_valid_ff;
	logic [127:0]           cpu_ret_data_ff;
	prhb_pkg::prhb_credit_t cpu_ret_tag_ff;
	logic [4:0]             outstanding_ff;
	prhb_pkg::prhb_credit_t alloc_tag;
	logic                   accept;
	logic [1:0]             nxt_cmd;
	logic [1:0]             nxt_buf;

	// lowest free credit; picking lowest keeps reuse order predictable
	function automatic prhb_pkg::prhb_credit_t first_free(input logic [15:0] v);
		prhb_pkg::prhb_credit_t r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [4:0] count_ones(input logic [15:0] v);
		logic [4:0] c;
		c = 5'h0;
		for (int i = 0; i < 16; i++) begin
			c = c + {4'h0, v[i]};
		end
		return c;
	endfunction

	// ready is registered, so it reflects the pool before this cycle's returns and allocation
	assign accept    = req_valid && req_ready_ff;
	assign alloc_tag = first_free(free_ff);

	always_comb begin
		nxt_free = free_ff;
		if (credit_ret_valid) begin
			nxt_free[credit_ret_tag] = 1'b1;
		end
		if (rd_ret_valid) begin
			nxt_free[rd_ret_tag] = 1'b1;
		end
		if (accept) begin
			nxt_free[alloc_tag] = 1'b0;
		end
	end

	// credit pool: a tag is reused only after it came back
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			free_ff        <= `PRHB_FREE_RST;
			req_ready_ff   <= 1'b1;
			outstanding_ff <= 5'h0;
		end else begin
			free_ff        <= nxt_free;
			req_ready_ff   <= |nxt_free;
			outstanding_ff <= 5'(`PRHB_CREDITS) - count_ones(nxt_free);
		end
	end

	always_comb begin
		case (req_space)
			prhb_pkg::PRHB_SPACE_MEM64: nxt_cmd = `PRHB_CMD_MEM64;
			prhb_pkg::PRHB_SPACE_MEM32: nxt_cmd = `PRHB_CMD_MEM32;
			prhb_pkg::PRHB_SPACE_IO_CFG: begin
				nxt_cmd = {1'b0, req_physical_address[`PRHB_IO_SEL_BIT]};
			end
			default: nxt_cmd = `PRHB_CMD_MEM64;
		endcase
		nxt_buf = req_from_test_port ? `PRHB_BUF_TEST : `PRHB_BUF_NORMAL;
	end

	// header word; reserved top bits driven zero though the far end may not rely on it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hdr_valid_ff <= 1'b0;
			hdr_data_ff  <= 64'h0;
		end else begin
			hdr_valid_ff <= accept;
			if (accept) begin
				hdr_data_ff[`PRHB_RESV_HI:`PRHB_RESV_LO]   <= 3'h0;
				hdr_data_ff[`PRHB_RD_BIT]                  <= req_is_read;
				hdr_data_ff[`PRHB_CREDIT_HI:`PRHB_CREDIT_LO] <= alloc_tag;
				hdr_data_ff[`PRHB_SIZE_HI:`PRHB_SIZE_LO]   <= req_size;
				hdr_data_ff[`PRHB_TAG_HI:`PRHB_TAG_LO]     <= {nxt_buf, req_cpu_thread_id};
				hdr_data_ff[`PRHB_ZERO_HI:`PRHB_ZERO_LO]   <= 2'h0;
				hdr_data_ff[`PRHB_CMD_HI:`PRHB_CMD_LO]     <= nxt_cmd;
				// byte address kept whole; only the low 36 bits travel, masked
				hdr_data_ff[`PRHB_ADDR_HI:`PRHB_ADDR_LO]   <=
					req_physical_address[35:0] & cfg_addr_mask;
			end
		end
	end

	// per credit: was it a 16-byte read; only low three size bits decide
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			full16_ff <= 16'h0;
		end else if (accept) begin
			full16_ff[alloc_tag] <= req_is_read && (req_size[2:0] == `PRHB_SIZE_16B);
		end
	end

	// read return: 16-byte reads untouched, others get bits 127:64 in both halves; offset zero stays in the top byte of each word
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cpu_ret_valid_ff <= 1'b0;
			cpu_ret_data_ff  <= 128'h0;
			cpu_ret_tag_ff   <= 4'h0;
		end else begin
			cpu_ret_valid_ff <= rd_ret_valid;
			if (rd_ret_valid) begin
				cpu_ret_tag_ff <= rd_ret_tag;
				if (full16_ff[rd_ret_tag]) begin
					cpu_ret_data_ff <= rd_ret_data;
				end else begin
					cpu_ret_data_ff <= {2{rd_ret_data[127:64]}};
				end
			end
		end
	end

	assign req_ready     = req_ready_ff;
	assign hdr_valid     = hdr_valid_ff;
	assign hdr_data      = hdr_data_ff;
	assign cpu_ret_valid = cpu_ret_valid_ff;
	assign cpu_ret_data  = cpu_ret_data_ff;
	assign cpu_ret_tag   = cpu_ret_tag_ff;
	assign outstanding   = outstanding_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_accept;
		req_valid && req_ready_ff;
	endsequence

	property p_rd_flag;
		s_accept |=> hdr_valid_ff && (hdr_data_ff[60] == $past(req_is_read));
	endproperty
	a_rd_flag: assert property (p_rd_flag) else $error("read flag wrong");

	property p_zero_bits;
		hdr_valid_ff |-> (hdr_data_ff[39:38] == 2'h0);
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("bits 39:38 not zero");

	property p_credit_free;
		s_accept |-> free_ff[alloc_tag] ##1 !free_ff[hdr_data_ff[59:56]];
	endproperty
	a_credit_free: assert property (p_credit_free) else $error("credit reused");

	property p_limit;
		(outstanding_ff == 5'h10) |-> !req_ready_ff;
	endproperty
	a_limit: assert property (p_limit) else $error("more than 16 outstanding");

	property p_size;
		s_accept |=> (hdr_data_ff[55:48] == $past(req_size));
	endproperty
	a_size: assert property (p_size) else $error("size field altered");

	property p_tag;
		s_accept |=> (hdr_data_ff[45:40] == $past(req_cpu_thread_id))
			&& (hdr_data_ff[47:46] == ($past(req_from_test_port) ? 2'h1 : 2'h0));
	endproperty
	a_tag: assert property (p_tag) else $error("requester tag wrong");

	property p_cmd_io;
		(s_accept and (req_space == prhb_pkg::PRHB_SPACE_IO_CFG))
			|=> (hdr_data_ff[37:36] == {1'b0, $past(req_physical_address[28])});
	endproperty
	a_cmd_io: assert property (p_cmd_io) else $error("io/config command wrong");

	property p_addr;
		s_accept |=> (hdr_data_ff[35:0] == $past(req_physical_address[35:0] & cfg_addr_mask));
	endproperty
	a_addr: assert property (p_addr) else $error("bus address wrong");

	property p_repl;
		rd_ret_valid && !full16_ff[rd_ret_tag]
			|=> cpu_ret_valid_ff && (cpu_ret_data_ff[63:0] == cpu_ret_data_ff[127:64])
			&& (cpu_ret_data_ff[127:64] == $past(rd_ret_data[127:64]));
	endproperty
	a_repl: assert property (p_repl) else $error("short read not replicated");

	property p_full;
		rd_ret_valid && full16_ff[rd_ret_tag] |=> (cpu_ret_data_ff == $past(rd_ret_data));
	endproperty
	a_full: assert property (p_full) else $error("16-byte read altered");

endmodule
`default_nettype wire

// >>> prhb_io_unit_model.sv
// Purpose: behavioural model of the pci_io_unit side that takes request headers
// Assumes: one return per cycle, in the order the headers arrived
// Notes:   hold stalls all returns so the bench can run the credit pool dry
`timescale 1ns/10ps
`default_nettype none

module prhb_io_unit_model (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// stall control from the bench
	input  wire logic              hold,
	// headers from the builder
	input  wire logic              hdr_valid,
	input  wire logic [63:0]       hdr_data,
	// returns toward the builder
	output logic                   credit_ret_valid,
	output prhb_pkg::prhb_credit_t credit_ret_tag,
	output logic                   rd_ret_valid,
	output prhb_pkg::prhb_credit_t rd_ret_tag,
	output logic [127:0]           rd_ret_data
);
	logic [63:0] pend_q[$];
	logic [63:0] head;
	logic        go;

	// idle tag and data lines toggle so a stale value is never mistaken for a fresh one
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pend_q.delete();
			credit_ret_valid <= 1'b0;
			rd_ret_valid     <= 1'b0;
			credit_ret_tag   <= 4'h0;
			rd_ret_tag       <= 4'h0;
			rd_ret_data      <= 128'h0;
		end else begin
			if (hdr_valid)
				pend_q.push_back(hdr_data);
			go = !hold && pend_q.size() != 0;
			if (go)
				head = pend_q.pop_front();
			credit_ret_valid <= go && !head[60];
			rd_ret_valid     <= go && head[60];
			credit_ret_tag   <= go ? head[59:56] : ~credit_ret_tag;
			rd_ret_tag       <= go ? head[59:56] : ~rd_ret_tag;
			rd_ret_data      <= (go && head[60]) ? {64'h0123_4567_89AB_CDEF ^ {16{head[59:56]}},
				64'hFEDC_BA98_7654_3210} : ~rd_ret_data;
		end
	end
endmodule
`default_nettype wire

// >>> tb_prhb_builder.sv
// Purpose: self-checking bench for the request header builder
// Assumes: model answers in order; credit tags start from zero after reset
// Notes:   all requests are aligned and at most 16 bytes, as a processor must send
`timescale 1ns/10ps
`default_nettype none

module tb_prhb_builder;
	logic                   ref_clk = 1'b0;
	logic                   sys_rst = 1'b1;
	logic                   req_valid = 1'b0, req_is_read = 1'b0, req_from_test_port = 1'b0;
	logic                   hold = 1'b0;
	logic [7:0]             req_size = 8'h0;
	logic [5:0]             req_cpu_thread_id = 6'h0;
	logic [39:0]            req_physical_address = 40'h0;
	prhb_pkg::prhb_space_t  req_space = prhb_pkg::PRHB_SPACE_MEM64;
	logic [35:0]            cfg_addr_mask = 36'hF_0FFF_FF0F;
	logic                   req_ready, hdr_valid, cpu_ret_valid, credit_ret_valid, rd_ret_valid;
	logic [63:0]            hdr_data;
	logic [127:0]           rd_ret_data, cpu_ret_data;
	prhb_pkg::prhb_credit_t credit_ret_tag, rd_ret_tag, cpu_ret_tag;
	logic [4:0]             outstanding;
	int                     fail_count = 0, n_compared = 0;

	always #50 ref_clk = ~ref_clk;

	prhb_builder i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid),
		.req_is_read(req_is_read), .req_size(req_size), .req_cpu_thread_id(req_cpu_thread_id),
		.req_from_test_port(req_from_test_port), .req_physical_address(req_physical_address),
		.req_space(req_space), .cfg_addr_mask(cfg_addr_mask), .req_ready(req_ready),
		.hdr_valid(hdr_valid), .hdr_data(hdr_data), .credit_ret_valid(credit_ret_valid),
		.credit_ret_tag(credit_ret_tag), .rd_ret_valid(rd_ret_valid), .rd_ret_tag(rd_ret_tag),
		.rd_ret_data(rd_ret_data), .cpu_ret_valid(cpu_ret_valid), .cpu_ret_data(cpu_ret_data),
		.cpu_ret_tag(cpu_ret_tag), .outstanding(outstanding));

	prhb_io_unit_model i_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .hold(hold),
		.hdr_valid(hdr_valid), .hdr_data(hdr_data), .credit_ret_valid(credit_ret_valid),
		.credit_ret_tag(credit_ret_tag), .rd_ret_valid(rd_ret_valid), .rd_ret_tag(rd_ret_tag),
		.rd_ret_data(rd_ret_data));

	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			fail_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask

	// judged on the awaited condition itself, so a late but legal answer still counts
	task automatic give_up(input bit done, input string msg);
		if (!done) begin
			check(1'b0, msg);
			report_and_stop();
		end
	endtask

	// returns at the edge after acceptance, where the header pulse is visible
	task automatic send(input logic rd, input logic [7:0] sz, input logic [5:0] thr,
		input logic tp, input logic [39:0] phys, input prhb_pkg::prhb_space_t sp);
		int n;
		req_is_read <= rd;
		req_size <= sz;
		req_cpu_thread_id <= thr;
		req_from_test_port <= tp;
		req_physical_address <= phys;
		req_space <= sp;
		req_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		req_valid <= 1'b0;
		give_up(req_ready === 1'b1, "request never taken");
		@(posedge ref_clk);
	endtask

	// every space, direction and source, until the pool is empty
	task automatic t_fill_and_refuse();
		logic [3:0]            k;
		logic [39:0]           phys;
		logic [7:0]            sz;
		logic [1:0]            c;
		logic [63:0]           e;
		prhb_pkg::prhb_space_t sp;
		int                    n;
		hold <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			k = 4'(i);
			phys = {8'h80, 3'h5, k[0], 24'hA5C3E1, 4'h0};
			sz = {k, 2'h2, k[1:0]};
			// io/config on k 2,6,7,10,14,15: both address bit 28 values reach the command
			sp = (k[2:1] == 2'h3 || k[1:0] == 2'h2) ? prhb_pkg::PRHB_SPACE_IO_CFG :
				prhb_pkg::prhb_space_t'(k[1:0]);
			c = (sp == prhb_pkg::PRHB_SPACE_MEM32) ? 2'h2 :
				(sp == prhb_pkg::PRHB_SPACE_IO_CFG) ? {1'b0, phys[28]} : 2'h3;
			send(k[0], sz, {k[1:0], k}, k[1], phys, sp);
			e = {3'h0, k[0], k, sz, 1'b0, k[1], k[1:0], k, 2'h0, c, phys[35:0] & cfg_addr_mask};
			check(hdr_valid === 1'b1 && hdr_data[60:0] === e[60:0], "header");
		end
		check(outstanding === 5'h10 && req_ready === 1'b0, "pool not exhausted");
		req_valid <= 1'b1;
		repeat (3) begin
			@(posedge ref_clk);
			check(hdr_valid === 1'b0, "request taken with no credit");
		end
		req_valid <= 1'b0;
		hold <= 1'b0;
		n = 0;
		while (outstanding !== 5'h0 && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
		give_up(outstanding === 5'h0, "credits never came back");
		check(req_ready === 1'b1, "ready after drain");
	endtask

	// whole pool free beforehand, so the read takes credit zero
	task automatic t_read_ret(input logic [7:0] sz, input logic [39:0] phys, input logic whole);
		logic [63:0] hi;
		int          n;
		hi = 64'h0123_4567_89AB_CDEF;
		send(1'b1, sz, 6'h11, 1'b0, phys, prhb_pkg::PRHB_SPACE_MEM32);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cpu_ret_valid !== 1'b1 && n < 20);
		give_up(cpu_ret_valid === 1'b1, "no read return");
		check(cpu_ret_tag === 4'h0, "return tag");
		check(cpu_ret_data === (whole ? {hi, 64'hFEDC_BA98_7654_3210} : {2{hi}}), "return data");
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		check(req_ready === 1'b1 && outstanding === 5'h0, "reset state");
		t_fill_and_refuse();
		t_read_ret(8'hF9, 40'h80_0000_0004, 1'b0);
		t_read_ret(8'hFC, 40'h80_0000_0010, 1'b1);
		report_and_stop();
	end
endmodule
`default_nettype wire
